// [rtl/baud_pkg.sv]
// Purpose: Shared constants and types for the baud rate generator block
// Assumes: APB with 32-bit data, one aligned word per register
// Notes:   Byte addresses for registers are fixed here
`default_nettype none
package baud_pkg;
    localparam int          DIV_W            = 13;
    localparam int          OVS              = 16;
    localparam logic [11:0] ADDR_BAUD_HIGH   = 12'h000;
    localparam logic [11:0] ADDR_BAUD_LOW    = 12'h004;
    localparam logic [11:0] ADDR_CONTROL_TWO = 12'h008;
    localparam logic [11:0] ADDR_IRQ_STATUS  = 12'h00C;
    localparam logic [11:0] ADDR_IRQ_MASK    = 12'h010;
    localparam logic [11:0] ADDR_EVENT_SET   = 12'h014;
    localparam int          BIT_BRK_IE       = 7;
    localparam int          BIT_EDGE_IE      = 6;
    localparam int          BIT_UNUSED       = 5;
    localparam int          BIT_RX_ON        = 2;
    localparam int          BIT_TX_ON        = 3;
    localparam int          ST_BRK           = 0;
    localparam int          ST_EDGE          = 1;
    localparam int          ST_TICK          = 2;
    localparam int          ST_W             = 3;
    localparam logic [4:0]  RST_HIGH_DIV     = 5'h00;
    localparam logic [7:0]  RST_LOW_DIV      = 8'h04;
    localparam logic [3:0]  OVS_LAST         = 4'hF;

    typedef struct packed {
        logic             brk_ie;
        logic             edge_ie;
        logic [4:0]       div_high;
    } baud_high_t;

    typedef struct packed {
        logic             enable;
        logic [DIV_W-1:0] divisor;
    } gen_cfg_t;
endpackage : baud_pkg
`default_nettype wire

// [rtl/baud_divider.sv]
// Purpose: Modulo divisor counter producing one-cycle enable pulses
// Assumes: Divisor value is stable except at commit points
// Notes:   Output pulse rate is clock over divisor value
`default_nettype none
module baud_divider #(
    parameter int W = 13
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         run,
    input  wire logic [W-1:0] divisor,
    output logic              tick
);
    logic [W-1:0] cnt_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= '0;
            tick  <= 1'b0;
        end else if (!run || divisor == '0) begin
            cnt_r <= '0;
            tick  <= 1'b0;
        end else if (cnt_r >= divisor - W'(1)) begin
            cnt_r <= '0;
            tick  <= 1'b1;
        end else begin
            cnt_r <= cnt_r + W'(1);
            tick  <= 1'b0;
        end
    end
endmodule : baud_divider
`default_nettype wire

// [rtl/oversample_div.sv]
// Purpose: Divide oversample ticks by sixteen into baud ticks
// Assumes: Input tick is a one-cycle pulse
// Notes:   Cleared whenever the generator stops
`default_nettype none
module oversample_div (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic run,
    input  wire logic tick_in,
    output logic      tick_out
);
    logic [3:0] phase_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_r  <= '0;
            tick_out <= 1'b0;
        end else if (!run) begin
            phase_r  <= '0;
            tick_out <= 1'b0;
        end else begin
            tick_out <= tick_in && phase_r == baud_pkg::OVS_LAST;
            if (tick_in) begin
                phase_r <= phase_r + 4'h1;
            end
        end
    end
endmodule : oversample_div
`default_nettype wire

// [rtl/serial_baud_rate_generator.sv]
// Purpose: Baud divisor register pair with APB access and edge interrupts
// Assumes: APB master keeps a request stable until pready
// Notes:   Zero wait states; every access answers in its access cycle
`default_nettype none
// Overview of operation
// - Divisor is high five plus low eight
// - High divisor bits buffered until low write
// - Zero divisor stops the generator
// - Baud rate is clock over sixteen times divisor
// - Idle after reset until rx_on or tx_on set
// - Bit 7 gates break flag interrupt
// - Bit 6 gates edge flag interrupt
module serial_baud_rate_generator (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        break_detect_evt,
    input  wire logic        rx_edge_evt,
    output logic             baud_tick,
    output logic             oversample_tick,
    output logic             generator_on,
    output logic             irq
);
    baud_pkg::baud_high_t        high_work_r;
    logic [4:0]                  high_buf_r;
    logic [7:0]                  low_r;
    logic                        rx_on_r;
    logic                        tx_on_r;
    logic                        started_r;
    logic [baud_pkg::ST_W-1:0]   status_r;
    logic [baud_pkg::ST_W-1:0]   mask_r;
    logic [baud_pkg::ST_W-1:0]   event_vec;
    logic [baud_pkg::ST_W-1:0]   w1c_vec;
    logic [baud_pkg::ST_W-1:0]   sw_set_vec;
    baud_pkg::gen_cfg_t          cfg;
    logic                        wr_en;
    logic                        addr_ok;
    logic [31:0]                 rd_data;
    logic                        os_tick;
    logic                        bd_tick;
    logic                        irq_nxt;

    assign wr_en = psel && penable && pwrite;

    always_comb begin
        addr_ok = 1'b1;
        rd_data = 32'h0000_0000;
        unique case (paddr)
            baud_pkg::ADDR_BAUD_HIGH: begin
                rd_data[baud_pkg::BIT_BRK_IE]  = high_work_r.brk_ie;
                rd_data[baud_pkg::BIT_EDGE_IE] = high_work_r.edge_ie;
                rd_data[4:0]                   = high_work_r.div_high;
            end
            baud_pkg::ADDR_BAUD_LOW: begin
                rd_data[7:0] = low_r;
            end
            baud_pkg::ADDR_CONTROL_TWO: begin
                rd_data[baud_pkg::BIT_RX_ON] = rx_on_r;
                rd_data[baud_pkg::BIT_TX_ON] = tx_on_r;
            end
            baud_pkg::ADDR_IRQ_STATUS: begin
                rd_data[baud_pkg::ST_W-1:0] = status_r;
            end
            baud_pkg::ADDR_IRQ_MASK: begin
                rd_data[baud_pkg::ST_W-1:0] = mask_r;
            end
            baud_pkg::ADDR_EVENT_SET: begin
                rd_data = 32'h0000_0000;
            end
            default: begin
                addr_ok = 1'b0;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= 1'b1;
            pslverr <= psel && !penable && !addr_ok;
            if (psel && !penable && !pwrite) begin
                prdata <= rd_data;
            end
        end
    end

    // Enables and high divisor bits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            high_work_r <= '{brk_ie: 1'b0, edge_ie: 1'b0, div_high: baud_pkg::RST_HIGH_DIV};
            high_buf_r  <= baud_pkg::RST_HIGH_DIV;
        end else if (wr_en && paddr == baud_pkg::ADDR_BAUD_HIGH) begin
            high_work_r.brk_ie  <= pwdata[baud_pkg::BIT_BRK_IE];
            high_work_r.edge_ie <= pwdata[baud_pkg::BIT_EDGE_IE];
            high_buf_r          <= pwdata[4:0];
        end else if (wr_en && paddr == baud_pkg::ADDR_BAUD_LOW) begin
            high_work_r.div_high <= high_buf_r;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            low_r <= baud_pkg::RST_LOW_DIV;
        end else if (wr_en && paddr == baud_pkg::ADDR_BAUD_LOW) begin
            low_r <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_on_r   <= 1'b0;
            tx_on_r   <= 1'b0;
            started_r <= 1'b0;
        end else begin
            if (wr_en && paddr == baud_pkg::ADDR_CONTROL_TWO) begin
                rx_on_r <= pwdata[baud_pkg::BIT_RX_ON];
                tx_on_r <= pwdata[baud_pkg::BIT_TX_ON];
            end
            if (rx_on_r || tx_on_r) begin
                started_r <= 1'b1;
            end
        end
    end

    assign cfg.divisor = {high_work_r.div_high, low_r};
    assign cfg.enable  = started_r && cfg.divisor != '0;

    baud_divider #(
        .W (baud_pkg::DIV_W)
    ) u_div (
        .pclk    (pclk),
        .presetn (presetn),
        .run     (cfg.enable),
        .divisor (cfg.divisor),
        .tick    (os_tick)
    );

    oversample_div u_ovs (
        .pclk     (pclk),
        .presetn  (presetn),
        .run      (cfg.enable),
        .tick_in  (os_tick),
        .tick_out (bd_tick)
    );

    assign event_vec[baud_pkg::ST_BRK]  = break_detect_evt;
    assign event_vec[baud_pkg::ST_EDGE] = rx_edge_evt;
    assign event_vec[baud_pkg::ST_TICK] = bd_tick;

    assign w1c_vec    = (wr_en && paddr == baud_pkg::ADDR_IRQ_STATUS) ? pwdata[baud_pkg::ST_W-1:0] : '0;
    assign sw_set_vec = (wr_en && paddr == baud_pkg::ADDR_EVENT_SET) ? pwdata[baud_pkg::ST_W-1:0] : '0;

    // Sticky flags, set wins over clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_r <= '0;
        end else begin
            status_r <= (status_r & ~w1c_vec) | event_vec | sw_set_vec;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_r <= '0;
        end else if (wr_en && paddr == baud_pkg::ADDR_IRQ_MASK) begin
            mask_r <= pwdata[baud_pkg::ST_W-1:0];
        end
    end

    always_comb begin
        irq_nxt = |(status_r & mask_r);
        // Break flag gated by bit 7
        if (high_work_r.brk_ie && status_r[baud_pkg::ST_BRK]) begin
            irq_nxt = 1'b1;
        end
        // Edge flag gated by bit 6
        if (high_work_r.edge_ie && status_r[baud_pkg::ST_EDGE]) begin
            irq_nxt = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq             <= 1'b0;
            baud_tick       <= 1'b0;
            oversample_tick <= 1'b0;
            generator_on    <= 1'b0;
        end else begin
            irq             <= irq_nxt;
            baud_tick       <= bd_tick;
            oversample_tick <= os_tick;
            generator_on    <= cfg.enable;
        end
    end
endmodule : serial_baud_rate_generator
`default_nettype wire

// [verification/serial_baud_rate_generator_properties.sv]
// Purpose: Port checks for the baud generator
// Assumes: One clock, zero-wait APB
// Notes:   Shadows divisor and enables from bus writes
`default_nettype none
module baud_gen_checker (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        break_detect_evt,
    input wire logic        rx_edge_evt,
    input wire logic        baud_tick,
    input wire logic        oversample_tick,
    input wire logic        generator_on,
    input wire logic        irq
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [12:0] div_r;
    logic [4:0]  hold_r;
    logic [1:0]  ie_r;
    logic        seen_r;
    wire         wr = psel && penable && pwrite;
    wire         rd = psel && penable && !pwrite;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_r  <= {baud_pkg::RST_HIGH_DIV, baud_pkg::RST_LOW_DIV};
            hold_r <= 5'h00;
            ie_r   <= 2'h0;
            seen_r <= 1'b0;
        end else if (wr && paddr == baud_pkg::ADDR_BAUD_HIGH) begin
            hold_r <= pwdata[4:0];
            ie_r   <= pwdata[7:6];
        end else if (wr && paddr == baud_pkg::ADDR_BAUD_LOW) begin
            div_r  <= {hold_r, pwdata[7:0]};
        end else if (wr && paddr == baud_pkg::ADDR_CONTROL_TWO && pwdata[3:2] != 2'h0) begin
            seen_r <= 1'b1;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_ready; psel && penable |-> pready; endproperty
    a_ready: assert property (p_ready) else $error("access without ready");
    property p_hi; rd && paddr == baud_pkg::ADDR_BAUD_HIGH |-> prdata[7:0] == {ie_r, 1'b0, div_r[12:8]}; endproperty
    a_hi: assert property (p_hi) else $error("high register read wrong");
    property p_lo; rd && paddr == baud_pkg::ADDR_BAUD_LOW |-> prdata[7:0] == div_r[7:0]; endproperty
    a_lo: assert property (p_lo) else $error("low register read wrong");
    property p_idle; !seen_r |-> !generator_on; endproperty
    a_idle: assert property (p_idle) else $error("generator ran before enable");
    property p_zero; (div_r == 13'h0000) [*3] |-> !generator_on; endproperty
    a_zero: assert property (p_zero) else $error("generator on with zero divisor");
    property p_quiet; !generator_on [*4] |-> !baud_tick && !oversample_tick; endproperty
    a_quiet: assert property (p_quiet) else $error("tick while stopped");
    property p_brk; break_detect_evt && ie_r[1] |-> ##[1:3] irq; endproperty
    a_brk: assert property (p_brk) else $error("break event gave no irq");
    property p_edge; rx_edge_evt && ie_r[0] |-> ##[1:3] irq; endproperty
    a_edge: assert property (p_edge) else $error("edge event gave no irq");
endmodule : baud_gen_checker
bind serial_baud_rate_generator baud_gen_checker i_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .break_detect_evt, .rx_edge_evt, .baud_tick, .oversample_tick, .generator_on, .irq);
`default_nettype wire

// [verification/far_serial_model.sv]
// Purpose: Far-side event source for the baud block
// Assumes: Bench calls pulse from its own process
// Notes:   Events are one-cycle pulses
`default_nettype none
module far_serial_model (
    input  wire logic pclk,
    output var logic  brk,
    output var logic  edg
);
    timeunit 1ns;
    timeprecision 1ns;
    initial {brk, edg} = 2'b00;
    task automatic pulse(input int i);
        @(posedge pclk);
        if (i == 0) brk <= 1'b1; else edg <= 1'b1;
        @(posedge pclk);
        {brk, edg} <= 2'b00;
    endtask : pulse
endmodule : far_serial_model
`default_nettype wire

// [verification/serial_baud_rate_generator_tb.sv]
// Purpose: Self-checking bench for the baud generator
// Assumes: Zero-wait APB slave
// Notes:   Events come from the far-side model
`default_nettype none
module serial_baud_rate_generator_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [11:0] A_HI = baud_pkg::ADDR_BAUD_HIGH;
    localparam logic [11:0] A_LO = baud_pkg::ADDR_BAUD_LOW;
    localparam logic [11:0] A_C2 = baud_pkg::ADDR_CONTROL_TWO;
    localparam logic [11:0] A_ST = baud_pkg::ADDR_IRQ_STATUS;
    localparam logic [11:0] A_MK = baud_pkg::ADDR_IRQ_MASK;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic        pready, er, brk, edg, baud_tick, os_tick, gen_on, irq;
    logic        rd_err;
    int          err_total = 0;
    int          cmp_count = 0;
    int          g;
    always #10 pclk = ~pclk;
    far_serial_model i_far (.pclk(pclk), .brk(brk), .edg(edg));
    serial_baud_rate_generator i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(er),
        .break_detect_evt(brk), .rx_edge_evt(edg), .baud_tick(baud_tick), .oversample_tick(os_tick),
        .generator_on(gen_on), .irq(irq));
    task automatic wrap_up();
        if (err_total == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : wrap_up
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            err_total++;
            wrap_up();
        end
        rd = prdata;
        rd_err = er;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // Cycles between two ticks
    task automatic gap(input bit os);
        int n = 0;
        g = 0;
        while (n < 2000 && (os ? os_tick : baud_tick) !== 1'b1) begin n++; @(posedge pclk); end
        do begin g++; @(posedge pclk); end while (g < 2000 && (os ? os_tick : baud_tick) !== 1'b1);
    endtask : gap
    task automatic t_regs();
        apb(1'b0, A_HI, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, A_LO, 32'h0);
        chk(rd, {24'h0, baud_pkg::RST_LOW_DIV});
        apb(1'b1, A_HI, 32'hFF);
        apb(1'b0, A_HI, 32'h0);
        chk(rd, 32'hC0);
        apb(1'b1, A_LO, 32'h01);
        apb(1'b0, A_HI, 32'h0);
        chk(rd, 32'hDF);
        chk(32'(gen_on), 32'h0);
    endtask : t_regs
    task automatic t_irq();
        for (int i = 0; i < 2; i++) begin
            apb(1'b1, A_HI, 32'h80 >> i);
            i_far.pulse(i);
            repeat (3) @(posedge pclk);
            chk(32'(irq), 32'h1);
            apb(1'b1, A_ST, 32'h1 << i);
            apb(1'b1, A_HI, 32'h0);
            chk(32'(irq), 32'h0);
            i_far.pulse(i);
            repeat (3) @(posedge pclk);
            chk(32'(irq), 32'h0);
            apb(1'b0, A_ST, 32'h0);
            chk(rd, 32'h1 << i);
            apb(1'b1, A_MK, 32'h1 << i);
            repeat (2) @(posedge pclk);
            chk(32'(irq), 32'h1);
            apb(1'b1, A_ST, 32'h1 << i);
            apb(1'b1, A_MK, 32'h0);
            repeat (2) @(posedge pclk);
            chk(32'(irq), 32'h0);
        end
    endtask : t_irq
    task automatic t_rate();
        apb(1'b1, A_HI, 32'h0);
        apb(1'b1, A_LO, 32'h3);
        apb(1'b1, A_C2, 32'h8);
        gap(1'b1);
        chk(32'(g), 32'd3);
        chk(32'(gen_on), 32'h1);
        gap(1'b0);
        chk(32'(g), 32'd48);
        apb(1'b0, A_ST, 32'h0);
        chk(rd & (32'h1 << baud_pkg::ST_TICK), 32'h1 << baud_pkg::ST_TICK);
        apb(1'b1, A_HI, 32'h1);
        gap(1'b0);
        chk(32'(g), 32'd48);
    endtask : t_rate
    task automatic t_zero();
        apb(1'b1, A_HI, 32'h0);
        apb(1'b1, A_LO, 32'h0);
        repeat (4) @(posedge pclk);
        chk(32'(gen_on), 32'h0);
        g = 0;
        repeat (200) begin @(posedge pclk); g += int'(baud_tick === 1'b1 || os_tick === 1'b1); end
        chk(32'(g), 32'h0);
        apb(1'b1, A_ST, 32'h7);
        apb(1'b1, baud_pkg::ADDR_EVENT_SET, 32'h2);
        apb(1'b0, A_ST, 32'h0);
        chk(rd, 32'h2);
        apb(1'b0, baud_pkg::ADDR_EVENT_SET, 32'h0);
        chk(rd, 32'h0);
    endtask : t_zero
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_irq();
        t_rate();
        t_zero();
        apb(1'b0, 12'h020, 32'h0);
        chk(32'(rd_err), 32'h1);
        chk(rd, 32'h0);
        wrap_up();
    end
endmodule : serial_baud_rate_generator_tb
`default_nettype wire
